/* src/usr_buf2.sv */
// two-entry buffer with registered outputs and valid/ready on both sides
`timescale 1ns/1ps
module usr_buf2 #(
	parameter int W = 8
) (
	input wire logic i_clk, // system clock
	input wire logic i_reset_n, // async reset, active low
	input wire logic i_in_valid, // word offered
	input wire logic [W-1:0] i_in_data, // word offered
	output logic o_in_ready, // room for a word
	output logic o_out_valid, // word available
	output logic [W-1:0] o_out_data, // word available
	input wire logic i_out_ready // receiver takes word
);

	typedef struct packed {
		logic out_valid;
		logic [W-1:0] out_data;
		logic spare_valid;
		logic [W-1:0] spare_data;
	} usr_buf2_state_t;

	usr_buf2_state_t state;
	usr_buf2_state_t next_state;

	always_comb begin
		logic take;
		logic give;
		take = i_in_valid && !state.spare_valid;
		give = state.out_valid && i_out_ready;
		next_state = state;
		if (give || !state.out_valid) begin
			// the spare word always leaves first to keep order
			if (state.spare_valid) begin
				next_state.out_valid = 1'b1;
				next_state.out_data = state.spare_data;
				next_state.spare_valid = take;
				next_state.spare_data = i_in_data;
			end else begin
				next_state.out_valid = take;
				next_state.out_data = i_in_data;
			end
		end else if (take) begin
			next_state.spare_valid = 1'b1;
			next_state.spare_data = i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_in_ready = !state.spare_valid;
	assign o_out_valid = state.out_valid;
	assign o_out_data = state.out_data;

endmodule // usr_buf2

/* src/usr_pkg.sv */
// shared constants and types of the universal shift register block
package usr_pkg;

	// ************************************************************
	// word and bus geometry
	// ************************************************************
	localparam int USR_WIDTH = 8;
	localparam int USR_CNT_WIDTH = 16;
	localparam int USR_ADR_WIDTH = 8;

	// ************************************************************
	// operations, coded as {mode_sel_hi, mode_sel_lo}
	// ************************************************************
	typedef enum logic [1:0] {
		USR_HOLD = 2'b00,
		USR_SHR = 2'b01,
		USR_SHL = 2'b10,
		USR_LOAD = 2'b11
	} usr_mode_t;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] USR_OFS_CTRL = 8'h00;
	localparam logic [7:0] USR_OFS_STATUS = 8'h04;
	localparam logic [7:0] USR_OFS_LOADS = 8'h08;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int USR_CTRL_CAPTURE_BIT = 0;
	localparam int USR_STAT_WORD_LSB = 0;
	localparam int USR_STAT_MODE_LSB = 8;
	localparam int USR_STAT_DRIVE_BIT = 10;
	localparam int USR_STAT_FULL_BIT = 11;
	localparam int USR_STAT_OVF_BIT = 12;
	localparam int USR_STAT_OVF_CLR_BIT = 12;
	localparam logic USR_CTRL_RESET = 1'b0;
	localparam logic [15:0] USR_LOADS_RESET = 16'h0000;

endpackage : usr_pkg

/* src/usr_stage.sv */
// one storage stage of the shift register with its operation mux
`timescale 1ns/1ps
module usr_stage (
	input wire logic i_clk, // system clock
	input wire logic i_clear_n, // async clear, active low
	input wire logic i_step, // one-cycle shift clock rise
	input wire usr_pkg::usr_mode_t i_mode, // selected operation
	input wire logic i_from_lower, // stage n-1 or right serial in
	input wire logic i_from_upper, // stage n+1 or left serial in
	input wire logic i_par, // parallel pin n input
	output logic o_q // stage contents
);

	typedef struct packed {
		logic q;
	} usr_stage_state_t;

	usr_stage_state_t state;
	usr_stage_state_t next_state;

	always_comb begin
		next_state = state;
		if (i_step) begin
			unique case (i_mode)
				usr_pkg::USR_HOLD: next_state.q = state.q;
				usr_pkg::USR_SHR: next_state.q = i_from_lower;
				usr_pkg::USR_SHL: next_state.q = i_from_upper;
				usr_pkg::USR_LOAD: next_state.q = i_par;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_clear_n) begin
		if (!i_clear_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_q = state.q;

endmodule // usr_stage

/* src/usr_top.sv */
// eight-stage universal shift register with wishbone status and capture
//
// Behaviour
// - eight edge-triggered stages form one byte
// - master clear low forces all stages low
// - stages change only on shift clock rise
// - both selects low holds the contents
// - both selects high loads pins into stages
// - shift right: serial in to stage 0
// - shift left: serial in to stage 7
// - either enable high floats parallel pins
// - load mode also turns pin drivers off
// - core keeps working while pins float
// - stage 0 and 7 always on taps
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module usr_top (
	input wire logic i_clk, // system clock, 100 MHz
	input wire logic i_reset_n, // async reset, active low
	input wire logic i_master_clear_n, // async stage clear, active low
	input wire logic i_shift_clock, // shift clock, sampled
	input wire logic i_mode_sel_lo, // mode select low bit
	input wire logic i_mode_sel_hi, // mode select high bit
	input wire logic i_out_en_n_a, // pin output enable a, low
	input wire logic i_out_en_n_b, // pin output enable b, low
	input wire logic i_ser_in_right, // shift-right serial input
	input wire logic i_ser_in_left, // shift-left serial input
	input wire logic [7:0] i_par_pin_in, // parallel pin levels
	output logic [7:0] o_par_pin_out, // parallel pin drive value
	output logic o_par_pin_oe, // parallel pin drivers on
	output logic o_tap_first_stage, // stage 0 serial tap
	output logic o_tap_last_stage, // stage 7 serial tap
	output logic o_load_ready, // capture buffer has room
	output logic o_word_valid, // captured word available
	output logic [7:0] o_word_data, // captured word
	input wire logic i_word_ready, // receiver takes word
	input wire logic i_wb_cyc, // wishbone cycle
	input wire logic i_wb_stb, // wishbone strobe
	input wire logic i_wb_we, // wishbone write
	input wire logic [7:0] i_wb_adr, // wishbone byte address
	input wire logic [3:0] i_wb_sel, // wishbone byte lanes
	input wire logic [31:0] i_wb_dat, // wishbone write data
	output logic [31:0] o_wb_dat, // wishbone read data
	output logic o_wb_ack // wishbone acknowledge
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic prev_shift_clock;
		logic drive;
		logic capture_en;
		logic overflow;
		logic [15:0] load_count;
		logic ack;
		logic [31:0] rdata;
	} usr_top_state_t;

	usr_top_state_t state;
	usr_top_state_t next_state;

	usr_pkg::usr_mode_t mode;
	logic step;
	logic clear_n;
	logic [7:0] stage;
	logic push;
	logic buf_in_ready;
	logic bus_req;
	logic bus_wr;

	assign mode = usr_pkg::usr_mode_t'({i_mode_sel_hi, i_mode_sel_lo});
	assign step = i_shift_clock && !state.prev_shift_clock;
	// clear path
	// the clear must act without the clock, so it joins the async reset
	assign clear_n = i_reset_n && i_master_clear_n;
	assign bus_req = i_wb_cyc && i_wb_stb && !state.ack;
	// writes land at the edge where the master sees ack, not before
	assign bus_wr = i_wb_cyc && i_wb_stb && state.ack && i_wb_we &&
		i_wb_sel[0];
	assign push = step && (mode == usr_pkg::USR_LOAD) && state.capture_en;

	// ************************************************************
	// storage stages
	// ************************************************************
	// eight stages
	genvar g;
	generate
		for (g = 0; g < usr_pkg::USR_WIDTH; g++) begin : g_stage
			logic lower;
			logic upper;
			if (g == 0) begin : g_lo_end
				assign lower = i_ser_in_right;
			end else begin : g_lo_mid
				assign lower = stage[g-1];
			end
			if (g == usr_pkg::USR_WIDTH - 1) begin : g_hi_end
				assign upper = i_ser_in_left;
			end else begin : g_hi_mid
				assign upper = stage[g+1];
			end
			usr_stage u_stage (
				.i_clk(i_clk),
				.i_clear_n(clear_n),
				.i_step(step),
				.i_mode(mode),
				.i_from_lower(lower),
				.i_from_upper(upper),
				.i_par(i_par_pin_in[g]),
				.o_q(stage[g])
			);
		end
	endgenerate

	// ************************************************************
	// capture buffer for loaded words
	// ************************************************************
	// a load with no room is still performed on the stages; only the
	// copy for the receiver is lost and flagged
	usr_buf2 #(
		.W(usr_pkg::USR_WIDTH)
	) u_buf (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(push),
		.i_in_data(i_par_pin_in),
		.o_in_ready(buf_in_ready),
		.o_out_valid(o_word_valid),
		.o_out_data(o_word_data),
		.i_out_ready(i_word_ready)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_state = state;
		next_state.prev_shift_clock = i_shift_clock;
		next_state.drive = !i_out_en_n_a && !i_out_en_n_b &&
			(mode != usr_pkg::USR_LOAD);
		// load counter: a clear write and a load in the same cycle leave the count at 1
		if (bus_wr && i_wb_adr == usr_pkg::USR_OFS_LOADS) begin
			next_state.load_count = usr_pkg::USR_LOADS_RESET;
		end
		if (step && mode == usr_pkg::USR_LOAD) begin
			if (bus_wr && i_wb_adr == usr_pkg::USR_OFS_LOADS) begin
				next_state.load_count = 16'h0001;
			end else begin
				next_state.load_count = state.load_count + 16'h0001;
			end
		end
		if (bus_wr && i_wb_adr == usr_pkg::USR_OFS_CTRL) begin
			next_state.capture_en =
				i_wb_dat[usr_pkg::USR_CTRL_CAPTURE_BIT];
		end
		if (bus_wr && i_wb_adr == usr_pkg::USR_OFS_STATUS &&
			i_wb_dat[usr_pkg::USR_STAT_OVF_CLR_BIT]) begin
			next_state.overflow = 1'b0;
		end
		// overflow set wins over its clear
		if (push && !buf_in_ready) begin
			next_state.overflow = 1'b1;
		end
		next_state.ack = bus_req;
		next_state.rdata = 32'h0000_0000;
		if (bus_req && !i_wb_we) begin
			unique case (i_wb_adr)
				usr_pkg::USR_OFS_CTRL: begin
					next_state.rdata[usr_pkg::USR_CTRL_CAPTURE_BIT] =
						state.capture_en;
				end
				usr_pkg::USR_OFS_STATUS: begin
					next_state.rdata[usr_pkg::USR_STAT_WORD_LSB +: 8] =
						stage;
					next_state.rdata[usr_pkg::USR_STAT_MODE_LSB +: 2] =
						mode;
					next_state.rdata[usr_pkg::USR_STAT_DRIVE_BIT] =
						state.drive;
					next_state.rdata[usr_pkg::USR_STAT_FULL_BIT] =
						!buf_in_ready;
					next_state.rdata[usr_pkg::USR_STAT_OVF_BIT] =
						state.overflow;
				end
				usr_pkg::USR_OFS_LOADS: begin
					next_state.rdata[15:0] = state.load_count;
				end
				default: begin
					next_state.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state.prev_shift_clock <= 1'b0;
			state.drive <= 1'b0;
			state.capture_en <= usr_pkg::USR_CTRL_RESET;
			state.overflow <= 1'b0;
			state.load_count <= usr_pkg::USR_LOADS_RESET;
			state.ack <= 1'b0;
			state.rdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// pins carry stages
	assign o_par_pin_out = stage;
	assign o_par_pin_oe = state.drive;
	assign o_tap_first_stage = stage[0];
	assign o_tap_last_stage = stage[usr_pkg::USR_WIDTH-1];
	// room left in the capture buffer
	assign o_load_ready = buf_in_ready;
	assign o_wb_ack = state.ack;
	assign o_wb_dat = state.rdata;

	// ************************************************************
	// assertions
	// ************************************************************
	property p_clear_zero;
		@(posedge i_clk) disable iff (!i_reset_n)
		(!i_master_clear_n)[*2] |-> stage == 8'h00;
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("stages not cleared under master clear");

	property p_no_step_stable;
		@(posedge i_clk) disable iff (!clear_n)
		!step ##1 i_master_clear_n |-> $stable(stage);
	endproperty
	a_no_step_stable: assert property (p_no_step_stable)
		else $error("stages changed without a shift clock rise");

	property p_hold;
		@(posedge i_clk) disable iff (!clear_n)
		step && mode == usr_pkg::USR_HOLD ##1 i_master_clear_n
			|-> $stable(stage);
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold mode changed the stages");

	property p_load;
		@(posedge i_clk) disable iff (!clear_n)
		step && mode == usr_pkg::USR_LOAD ##1 i_master_clear_n
			|-> stage == $past(i_par_pin_in);
	endproperty
	a_load: assert property (p_load)
		else $error("parallel load took wrong value");

	property p_shr;
		@(posedge i_clk) disable iff (!clear_n)
		step && mode == usr_pkg::USR_SHR ##1 i_master_clear_n
			|-> stage == {$past(stage[6:0]), $past(i_ser_in_right)};
	endproperty
	a_shr: assert property (p_shr)
		else $error("shift right gave wrong word");

	property p_shl;
		@(posedge i_clk) disable iff (!clear_n)
		step && mode == usr_pkg::USR_SHL ##1 i_master_clear_n
			|-> stage == {$past(i_ser_in_left), $past(stage[7:1])};
	endproperty
	a_shl: assert property (p_shl)
		else $error("shift left gave wrong word");

	property p_oe_off;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_out_en_n_a || i_out_en_n_b |=> !o_par_pin_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("pins driven while an enable is high");

	property p_load_off;
		@(posedge i_clk) disable iff (!i_reset_n)
		mode == usr_pkg::USR_LOAD |=> !o_par_pin_oe;
	endproperty
	a_load_off: assert property (p_load_off)
		else $error("pins driven in load mode");

	property p_oe_on;
		@(posedge i_clk) disable iff (!i_reset_n)
		!i_out_en_n_a && !i_out_en_n_b &&
			mode != usr_pkg::USR_LOAD |=> o_par_pin_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("pins not driven while enabled");

	property p_taps;
		@(posedge i_clk) disable iff (!clear_n)
		step && mode == usr_pkg::USR_SHR ##1 i_master_clear_n
			|-> o_tap_first_stage == $past(i_ser_in_right) &&
			o_tap_last_stage == $past(stage[6]);
	endproperty
	a_taps: assert property (p_taps)
		else $error("taps did not follow the shifted word");

	property p_clear_now;
		@(posedge i_clk) disable iff (!i_reset_n)
		!i_master_clear_n |-> o_par_pin_out == 8'h00 &&
			!o_tap_first_stage && !o_tap_last_stage;
	endproperty
	a_clear_now: assert property (p_clear_now)
		else $error("outputs not low while master clear is low");

	// ack lasts one cycle even if the strobe stays up
	property p_ack_pulse;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("bus acknowledge longer than one cycle");

	property p_ovf_set;
		@(posedge i_clk) disable iff (!i_reset_n)
		push && !buf_in_ready |=> state.overflow;
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("lost capture did not set overflow");

	property p_word_hold;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_word_valid && !i_word_ready |=>
			o_word_valid && $stable(o_word_data);
	endproperty
	a_word_hold: assert property (p_word_hold)
		else $error("captured word changed before it was taken");

	c_load: cover property (@(posedge i_clk) disable iff (!clear_n)
		step && mode == usr_pkg::USR_LOAD);
	c_shift_floating: cover property (@(posedge i_clk)
		disable iff (!clear_n)
		step && mode == usr_pkg::USR_SHL && !o_par_pin_oe);
	c_overflow: cover property (@(posedge i_clk)
		disable iff (!i_reset_n) push && !buf_in_ready);
	c_word_taken: cover property (@(posedge i_clk)
		disable iff (!i_reset_n) o_word_valid && i_word_ready);

endmodule // usr_top

/* test/usr_bus_model.sv */
// far-side bus logic sharing the eight parallel pins with the register
`timescale 1ns/1ps
module usr_bus_model (
	input wire logic i_clk, // system clock
	input wire logic i_dev_oe, // device drives the pins
	input wire logic [7:0] i_dev_out, // device pin values
	input wire logic i_drive, // bus logic wants to drive
	input wire logic [7:0] i_data, // bus logic value
	output logic [7:0] o_pins // resolved pin levels
);
	// ************************************************************
	// pin resolution
	// ************************************************************
	logic [7:0] last = 8'h00;
	always_ff @(posedge i_clk) begin
		last <= o_pins;
	end
	// drive only while device is off
	always_comb begin
		if (i_dev_oe) begin
			o_pins = i_dev_out;
		end else if (i_drive) begin
			o_pins = i_data;
		end else begin
			// no pull on these pins: never show a stale level
			o_pins = ~last;
		end
	end
endmodule // usr_bus_model

/* test/usr_top_test.sv */
// self-checking bench of the universal shift register with its bus model
`timescale 1ns/1ps
module usr_top_test;
	logic i_clk = 1'b0, i_reset_n = 1'b0, mclr_n = 1'b1, sclk = 1'b0;
	logic sel_lo = 1'b0, sel_hi = 1'b0, en_a = 1'b1, en_b = 1'b1;
	logic sr = 1'b0, sl = 1'b0, word_ready = 1'b0, cyc = 1'b0;
	logic stb = 1'b0, we = 1'b0, drive = 1'b0, cap = 1'b0, ovf = 1'b0;
	logic [7:0] adr = 8'h00, pdata = 8'h00, m = 8'h00, pins, pout, wdata;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, wb_dat;
	logic oe, tap0, tap7, load_ready, word_valid, ack;
	logic [7:0] q[$];
	int mismatches = 0, n_tests = 0, loads = 0, seed = 32'h6cb3, i, k;
	always #5 i_clk = ~i_clk;
	usr_top u_usr_top (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_master_clear_n(mclr_n), .i_shift_clock(sclk),
		.i_mode_sel_lo(sel_lo), .i_mode_sel_hi(sel_hi),
		.i_out_en_n_a(en_a), .i_out_en_n_b(en_b), .i_ser_in_right(sr),
		.i_ser_in_left(sl), .i_par_pin_in(pins), .o_par_pin_out(pout),
		.o_par_pin_oe(oe), .o_tap_first_stage(tap0),
		.o_tap_last_stage(tap7), .o_load_ready(load_ready),
		.o_word_valid(word_valid), .o_word_data(wdata),
		.i_word_ready(word_ready), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(wb_dat), .o_wb_ack(ack));
	usr_bus_model u_usr_bus_model (.i_clk(i_clk), .i_dev_oe(oe),
		.i_dev_out(pout), .i_drive(drive), .i_data(pdata), .o_pins(pins));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic final_report;
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		sel <= 4'hf;
		// look between edges so the answer is seen while it stands
		do begin
			@(negedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			chk("wb_ack", 32'h1, 32'(ack));
			final_report();
		end
		r = wb_dat;
		@(posedge i_clk);
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic step(input logic [1:0] md, input logic s_r,
		input logic s_l, input logic [7:0] pd);
		logic oe_e;
		@(posedge i_clk);
		sel_hi <= md[1]; sel_lo <= md[0]; sr <= s_r; sl <= s_l;
		pdata <= pd; drive <= 1'b0;
		// far side waits until the device has let go of the pins
		repeat (2) @(posedge i_clk);
		drive <= (md == 2'b11);
		sclk <= 1'b1;
		@(posedge i_clk);
		sclk <= 1'b0;
		case (md)
			2'b01: m = {m[6:0], s_r};
			2'b10: m = {s_l, m[7:1]};
			2'b11: begin
				m = pd;
				loads++;
				if (cap && q.size() < 2) q.push_back(pd);
				else if (cap) ovf = 1'b1;
			end
			default: m = m;
		endcase
		// steps are ignored while master clear is low
		if (!mclr_n) m = 8'h00;
		@(negedge i_clk);
		oe_e = !en_a && !en_b && md != 2'b11;
		chk("stage_outputs", 32'({tap7, tap0, oe, pout}),
			32'({m[7], m[0], oe_e, m}));
	endtask
	task automatic status(input logic [1:0] md);
		wb(1'b0, usr_pkg::USR_OFS_STATUS, 32'h0, rdat);
		chk("status", 32'({ovf, q.size() == 2,
			!en_a && !en_b && md != 2'b11, md, m}), 32'(rdat[12:0]));
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		chk("reset_out", 32'h10,
			32'({load_ready, word_valid, oe, tap0, tap7}));
		chk("reset_pins", 32'h0, 32'({ack, pout}));
		chk("reset_dat", 32'h0, wb_dat);
		@(posedge i_clk);
		i_reset_n <= 1'b1; en_a <= 1'b0; en_b <= 1'b0;
		wb(1'b0, usr_pkg::USR_OFS_CTRL, 32'h0, rdat);
		chk("ctrl_reset", 32'h0, rdat);
		step(2'b11, 1'b0, 1'b0, 8'($random(seed)));
		for (i = 0; i < 8; i++) begin
			step(2'b01, 1'($random(seed)), 1'b0, 8'h00);
			step(2'b10, 1'b0, 1'($random(seed)), 8'h00);
			step(2'b00, 1'($random(seed)), 1'b1, 8'hff);
		end
		for (k = 0; k < 4; k++) begin
			@(posedge i_clk);
			{en_a, en_b} <= 2'(k);
			step(2'b01, 1'($random(seed)), 1'b0, 8'h00);
			step(2'b10, 1'b0, 1'($random(seed)), 8'h00);
			step(2'b11, 1'b0, 1'b0, 8'($random(seed)));
		end
		@(posedge i_clk);
		mclr_n <= 1'b0;
		m = 8'h00;
		@(negedge i_clk);
		chk("clear", 32'h0, 32'({tap7, tap0, pout}));
		step(2'b01, 1'b1, 1'b0, 8'h00);
		@(posedge i_clk);
		mclr_n <= 1'b1;
		wb(1'b1, usr_pkg::USR_OFS_CTRL, 32'h1, rdat);
		cap = 1'b1;
		for (i = 0; i < 3; i++) begin
			step(2'b11, 1'b0, 1'b0, 8'($random(seed)));
		end
		chk("load_ready", 32'h0, 32'(load_ready));
		status(2'b11);
		wb(1'b0, usr_pkg::USR_OFS_LOADS, 32'h0, rdat);
		chk("loads", 32'(loads), 32'(rdat[15:0]));
		for (i = 0; i < 60 && q.size() > 0; i++) begin
			@(negedge i_clk);
			if (word_valid === 1'b1 && word_ready === 1'b1) begin
				chk("word", 32'(q.pop_front()), 32'(wdata));
			end
			@(posedge i_clk);
			word_ready <= (q.size() > 0) ? 1'($random(seed)) : 1'b0;
		end
		chk("drained", 32'h0, 32'(q.size()));
		wb(1'b1, usr_pkg::USR_OFS_STATUS, 32'h1000, rdat);
		ovf = 1'b0;
		status(2'b11);
		wb(1'b1, usr_pkg::USR_OFS_LOADS, 32'h0, rdat);
		wb(1'b0, usr_pkg::USR_OFS_LOADS, 32'h0, rdat);
		chk("loads_clr", 32'h0, rdat);
		wb(1'b1, 8'h0c, 32'h0, rdat);
		wb(1'b0, 8'h0c, 32'h0, rdat);
		chk("unmapped", 32'h0, rdat);
		wb(1'b0, usr_pkg::USR_OFS_CTRL, 32'h0, rdat);
		chk("ctrl", 32'h1, rdat);
		final_report();
	end
endmodule // usr_top_test
